// ### hdl/nprc_pkg.sv
// constants, types and helpers shared by the nested priority interrupt controller
package nprc_pkg;

	// ****************************************
	// sizes and register map
	// ****************************************
	localparam int          NUM_VEC      = 14;
	localparam int          NUM_EXT      = 5;
	localparam int          NUM_PERI     = 8;
	localparam int          FIRST_PERI   = 6;
	localparam int          LVL_BIT_HIGH = 5;
	localparam int          LVL_BIT_LOW  = 3;
	localparam logic [7:0]  ADDR_PRIO0   = 8'h00;
	localparam logic [7:0]  ADDR_PRIO1   = 8'h04;
	localparam logic [7:0]  ADDR_PRIO2   = 8'h08;
	localparam logic [7:0]  ADDR_PRIO3   = 8'h0C;
	localparam logic [7:0]  ADDR_EXTSEL0 = 8'h10;
	localparam logic [7:0]  ADDR_EXTSEL1 = 8'h14;
	localparam logic [7:0]  ADDR_PERIEN  = 8'h18;
	localparam logic [7:0]  ADDR_PEND    = 8'h1C;
	localparam int          NMI_EDGE_BIT = 8;
	localparam logic [3:0]  PRIO3_TOP    = 4'hF;

	// ****************************************
	// reset values and codes
	// ****************************************
	localparam logic [1:0]  PRIO_RST     = 2'h3;
	localparam logic [31:0] EXTSEL0_RST  = 32'h00000000;
	localparam logic [7:0]  EXTSEL1_RST  = 8'h00;
	localparam logic        NMI_EDGE_RST = 1'b0;
	localparam logic [7:0]  PERIEN_RST   = 8'h00;
	localparam logic [1:0]  LVL_CODE_0   = 2'h2;
	localparam logic [1:0]  LVL_CODE_1   = 2'h1;
	localparam logic [1:0]  LVL_CODE_2   = 2'h0;
	localparam logic [1:0]  LVL_CODE_3   = 2'h3;
	localparam logic [2:0]  LVL_NMASK    = 3'h4;
	localparam logic [15:0] VEC_RESET    = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP     = 16'hFFFC;
	localparam logic [15:0] VEC_BASE0    = 16'hFFFA;
	localparam logic [13:0] HALT_CAP     = 14'h01FF;
	localparam logic [4:0]  ID_TRAP      = 5'h0E;
	localparam logic [4:0]  ID_RESET     = 5'h0F;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        req;
		logic [15:0] vector;
		logic [1:0]  level;
		logic        stack;
		logic [4:0]  id;
	} nprc_req_t;

	typedef struct packed {
		logic       ack;
		logic       trap;
		logic       inWait;
		logic       inHalt;
		logic [7:0] conditionCodeReg;
	} nprc_core_t;

	// ****************************************
	// helpers
	// ****************************************
	// level code to rank 0..3
	function automatic logic [2:0] nprc_lvl(input logic [1:0] code);
		logic [2:0] r;
		r = 3'h0;
		unique case (code)
			LVL_CODE_0: r = 3'h0;
			LVL_CODE_1: r = 3'h1;
			LVL_CODE_2: r = 3'h2;
			LVL_CODE_3: r = 3'h3;
		endcase
		return r;
	endfunction

	function automatic logic [15:0] nprc_vec(input logic [4:0] id);
		logic [15:0] v;
		v = VEC_BASE0 - {10'h000, id, 1'b0};
		if (id == ID_RESET) begin
			v = VEC_RESET;
		end else if (id == ID_TRAP) begin
			v = VEC_TRAP;
		end
		return v;
	endfunction

endpackage

// ### hdl/nprc_ctrl.sv
// nested priority interrupt controller with AXI4-Lite priority and config registers
`timescale 1ns/10ps
module nprc_ctrl
	import nprc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output      logic        wready,
	output      logic [1:0]  bresp,
	output      logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output      logic        arready,
	output      logic [31:0] rdata,
	output      logic [1:0]  rresp,
	output      logic        rvalid,
	input  wire logic        rready,
	input  wire logic        nmiPin,
	input  wire logic [39:0] extPins,
	input  wire logic [7:0]  periphFlag,
	input  wire logic [7:0]  periphClear,
	input  wire nprc_core_t  coreIn,
	output      nprc_req_t   coreReq,
	output      logic        wakeWait,
	output      logic        wakeHalt
);

	// ****************************************
	// state
	// ****************************************
	logic [1:0]  prio [NUM_VEC];
	logic [31:0] extSel0;
	logic [7:0]  extSel1;
	logic        nmiRising;
	logic [7:0]  periEn;
	logic [13:0] pend;
	logic        trapPend;
	logic        resetPend;
	logic        haltExit;
	logic        nmiPrev;
	logic [4:0]  extPrev;
	logic        awGot;
	logic        wGot;
	logic [7:0]  awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;

	// ****************************************
	// request sources
	// ****************************************
	wire logic [39:0] extSelAll = {extSel1, extSel0};
	wire logic [4:0]  extLine;
	wire logic        nmiEdge;
	wire logic [4:0]  extEdge;
	wire logic [7:0]  periReq;

	genvar g;
	generate
		for (g = 0; g < NUM_EXT; g++) begin : gExt
			assign extLine[g] = |(extPins[8*g +: 8] & extSelAll[8*g +: 8]);
		end
	endgenerate

	assign nmiEdge = nmiRising ? (nmiPin & ~nmiPrev) : (~nmiPin & nmiPrev);
	assign extEdge = extLine & ~extPrev;
	assign periReq = periphFlag & periEn;

	// ****************************************
	// arbitration
	// ****************************************
	wire logic [1:0] curCode = {coreIn.conditionCodeReg[LVL_BIT_HIGH],
		coreIn.conditionCodeReg[LVL_BIT_LOW]};
	// re-read every cycle, so a restored level after a return takes effect at once
	wire logic [2:0] curLvl  = nprc_lvl(curCode);
	wire logic       ackHit  = coreIn.ack & coreReq.req;

	logic       found;
	logic       haltAny;
	logic [4:0] bestId;
	logic [2:0] bestLvl;

	always_comb begin
		logic [2:0] lv;
		logic       ok;
		lv      = 3'h0;
		ok      = 1'b0;
		found   = 1'b0;
		haltAny = 1'b0;
		bestId  = 5'h00;
		bestLvl = 3'h0;
		// walk from lowest hardware rank so higher ranks win ties
		for (int i = NUM_VEC - 1; i >= 0; i--) begin
			lv = (i == 0) ? LVL_NMASK : nprc_lvl(prio[i]);
			ok = pend[i] & ((i == 0) | (lv > curLvl));
			if (ok & HALT_CAP[i]) begin
				haltAny = 1'b1;
			end
			// mask while halted too, so no non-capable winner leaks out before haltExit sets
			if ((haltExit | coreIn.inHalt) & ~HALT_CAP[i]) begin
				ok = 1'b0;
			end
			if (ok & (~found | (lv >= bestLvl))) begin
				found   = 1'b1;
				bestId  = 5'(i);
				bestLvl = lv;
			end
		end
		if (trapPend) begin
			found   = 1'b1;
			bestId  = ID_TRAP;
			bestLvl = LVL_NMASK;
		end
		if (resetPend) begin
			found   = 1'b1;
			haltAny = 1'b1;
			bestId  = ID_RESET;
			bestLvl = LVL_NMASK;
		end
	end

	wire logic       bestNmask = (bestLvl == LVL_NMASK);
	wire logic [1:0] bestCode  = bestNmask ? LVL_CODE_3 : prio[bestId[3:0]];
	wire nprc_req_t  nextReq   = '{req: found, vector: nprc_vec(bestId), level: bestCode,
		stack: (bestId != ID_RESET), id: bestId};

	// ****************************************
	// pending latches
	// ****************************************
	wire logic [13:0] ackMask  = (ackHit & (coreReq.id < ID_TRAP)) ?
		(14'h0001 << coreReq.id[3:0]) : 14'h0000;
	wire logic [13:0] setMask  = {periReq, extEdge, nmiEdge};
	// edge sources drop on entry, peripherals only by their clear sequence
	wire logic [13:0] clrMask  = {periphClear, ackMask[5:0]};
	wire logic [13:0] next_pend = setMask | (pend & ~clrMask);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend      <= 14'h0000;
			trapPend  <= 1'b0;
			resetPend <= 1'b1;
			nmiPrev   <= 1'b0;
			extPrev   <= 5'h00;
		end else if (ce) begin
			pend      <= next_pend;
			trapPend  <= coreIn.trap | (trapPend & ~(ackHit & (coreReq.id == ID_TRAP)));
			resetPend <= resetPend & ~(ackHit & (coreReq.id == ID_RESET));
			nmiPrev   <= nmiPin;
			extPrev   <= extLine;
		end
	end

	// ****************************************
	// core hand-off and wake
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coreReq  <= '0;
			wakeWait <= 1'b0;
			wakeHalt <= 1'b0;
			haltExit <= 1'b0;
		end else if (ce) begin
			// drop for one cycle after an acknowledge so a stale winner is never re-taken
			coreReq  <= ackHit ? nprc_req_t'('0) : nextReq;
			wakeWait <= found;
			wakeHalt <= haltAny;
			if (coreIn.inHalt & haltAny) begin
				haltExit <= 1'b1;
			end else if (ackHit) begin
				haltExit <= 1'b0;
			end
		end
	end

	// ****************************************
	// register decode
	// ****************************************
	wire logic       wrMapped = (awAddrQ[7:5] == 3'h0) & (awAddrQ[1:0] == 2'h0);
	wire logic       rdMapped = (araddr[7:5] == 3'h0) & (araddr[1:0] == 2'h0);
	wire logic       wrFire   = awGot & wGot & ~bvalid;
	wire logic       wrEn     = wrFire & wrMapped;
	wire logic       wrLane0  = wrEn & wStrbQ[0];
	wire logic [3:0] wrPrio;
	wire logic [7:0] prioByte [4];
	logic     [31:0] readData;

	assign wrPrio[0] = wrLane0 & (awAddrQ == ADDR_PRIO0);
	assign wrPrio[1] = wrLane0 & (awAddrQ == ADDR_PRIO1);
	assign wrPrio[2] = wrLane0 & (awAddrQ == ADDR_PRIO2);
	assign wrPrio[3] = wrLane0 & (awAddrQ == ADDR_PRIO3);

	generate
		for (g = 0; g < 3; g++) begin : gPrio
			assign prioByte[g] = {prio[4*g+3], prio[4*g+2], prio[4*g+1], prio[4*g]};
		end
	endgenerate
	assign prioByte[3] = {PRIO3_TOP, prio[13], prio[12]};

	always_comb begin
		readData = 32'h00000000;
		unique case (araddr)
			ADDR_PRIO0:   readData = {24'h000000, prioByte[0]};
			ADDR_PRIO1:   readData = {24'h000000, prioByte[1]};
			ADDR_PRIO2:   readData = {24'h000000, prioByte[2]};
			ADDR_PRIO3:   readData = {24'h000000, prioByte[3]};
			ADDR_EXTSEL0: readData = extSel0;
			ADDR_EXTSEL1: readData = {23'h000000, nmiRising, extSel1};
			ADDR_PERIEN:  readData = {24'h000000, periEn};
			ADDR_PEND:    readData = {16'h0000, resetPend, trapPend, pend};
			default:      readData = 32'h00000000;
		endcase
	end

	// ****************************************
	// priority and config registers
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int f = 0; f < NUM_VEC; f++) begin
				prio[f] <= PRIO_RST;
			end
		end else if (ce) begin
			for (int f = 0; f < NUM_VEC; f++) begin
				if (wrPrio[f / 4] & (wDataQ[2*(f%4) +: 2] != LVL_CODE_0)) begin
					prio[f] <= wDataQ[2*(f%4) +: 2];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			extSel0   <= EXTSEL0_RST;
			extSel1   <= EXTSEL1_RST;
			nmiRising <= NMI_EDGE_RST;
			periEn    <= PERIEN_RST;
		end else if (ce & wrEn) begin
			if (awAddrQ == ADDR_EXTSEL0) begin
				for (int b = 0; b < 4; b++) begin
					if (wStrbQ[b]) begin
						extSel0[8*b +: 8] <= wDataQ[8*b +: 8];
					end
				end
			end
			if ((awAddrQ == ADDR_EXTSEL1) & wStrbQ[0]) begin
				extSel1 <= wDataQ[7:0];
			end
			if ((awAddrQ == ADDR_EXTSEL1) & wStrbQ[1]) begin
				nmiRising <= wDataQ[NMI_EDGE_BIT];
			end
			if ((awAddrQ == ADDR_PERIEN) & wStrbQ[0]) begin
				periEn <= wDataQ[7:0];
			end
		end
	end

	// ****************************************
	// AXI4-Lite write channels
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awGot   <= 1'b0;
			awready <= 1'b1;
			awAddrQ <= 8'h00;
		end else if (ce) begin
			if (awvalid & awready) begin
				awGot   <= 1'b1;
				awready <= 1'b0;
				awAddrQ <= awaddr;
			end else if (bvalid & bready) begin
				awGot   <= 1'b0;
				awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wGot   <= 1'b0;
			wready <= 1'b1;
			wDataQ <= 32'h00000000;
			wStrbQ <= 4'h0;
		end else if (ce) begin
			if (wvalid & wready) begin
				wGot   <= 1'b1;
				wready <= 1'b0;
				wDataQ <= wdata;
				wStrbQ <= wstrb;
			end else if (bvalid & bready) begin
				wGot   <= 1'b0;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (wrFire) begin
				bvalid <= 1'b1;
				bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channels
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid & arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= readData;
				rresp   <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid & rready) begin
				arready <= 1'b1;
				rvalid  <= 1'b0;
			end
		end
	end

endmodule // nprc_ctrl

// ### bench/nprc_ctrl_properties.sv
// concurrent checks on the controller ports
`timescale 1ns/10ps
module nprc_ctrl_check
	import nprc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       awvalid,
	input wire logic       awready,
	input wire logic       wvalid,
	input wire logic       wready,
	input wire logic       bvalid,
	input wire logic       arvalid,
	input wire logic       arready,
	input wire logic       rvalid,
	input wire nprc_core_t coreIn,
	input wire nprc_req_t  coreReq,
	input wire logic       wakeWait
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	function automatic int rk(input logic [1:0] c);
		return (c == 2'h2) ? 0 : (c == 2'h1) ? 1 : (c == 2'h0) ? 2 : 3;
	endfunction

	wire logic [1:0] lvlCode = {coreIn.conditionCodeReg[5], coreIn.conditionCodeReg[3]};
	wire logic       nmk = coreReq.req && (coreReq.id == 5'h00 || coreReq.id >= ID_TRAP);
	wire logic       msk = coreReq.req && coreReq.id != 5'h00 && coreReq.id < ID_TRAP;

	sequence ackTaken;
		coreIn.ack && coreReq.req;
	endsequence
	sequence wrBoth;
		awvalid && awready && wvalid && wready;
	endsequence

	a_nonmask_level: assert property (nmk |-> coreReq.level == LVL_CODE_3)
		else $error("nonmaskable level wrong");
	a_vector_map: assert property (coreReq.req |-> coreReq.vector ==
		((coreReq.id == ID_RESET) ? 16'hFFFE : (coreReq.id == ID_TRAP) ? 16'hFFFC :
		16'hFFFA - {10'h000, coreReq.id, 1'b0}))
		else $error("vector address wrong");
	a_reset_nostack: assert property (coreReq.req |-> coreReq.stack == (coreReq.id != ID_RESET))
		else $error("stack flag wrong");
	a_ack_drop: assert property (ackTaken |=> !coreReq.req)
		else $error("request kept after ack");
	// level bits may have just moved, so either side of the edge is accepted
	a_mask_strict: assert property (msk |-> rk(coreReq.level) > rk(lvlCode) ||
		rk(coreReq.level) > rk($past(lvlCode)))
		else $error("masked request shown");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	// both taken at one edge, bvalid raised the edge after, seen high one edge later
	a_write_answer: assert property (wrBoth |-> ##2 bvalid)
		else $error("write answer late");
	a_wake_wait: assert property ($rose(coreReq.req) |-> $past(wakeWait) or ##[0:1] wakeWait)
		else $error("no wake from wait");
endmodule // nprc_ctrl_check

// ### bench/nprc_core_model.sv
// core-side model: acknowledges, stacks and loads the level bits
`timescale 1ns/10ps
module nprc_core_model
	import nprc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire nprc_req_t  coreReq,
	input  wire logic       ackGo,
	input  wire logic       retGo,
	input  wire logic       trapGo,
	input  wire logic       haltGo,
	input  wire logic [2:0] lvlSet,
	output      nprc_core_t coreIn
);
	logic [7:0]  condReg;
	logic [7:0]  stk [0:7];
	logic [2:0]  sp;
	logic        ackHold;
	logic [15:0] pc;

	assign coreIn = '{ack: ackHold, trap: trapGo, inWait: 1'b0, inHalt: haltGo,
		conditionCodeReg: condReg};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			condReg <= 8'hEA;
			sp <= 3'h0;
			pc <= 16'h0000;
			ackHold <= 1'b0;
		end else begin
			// ack only at an instruction boundary, one cycle wide
			ackHold <= ackGo && coreReq.req && !ackHold;
			if (ackHold && coreReq.req) begin
				if (coreReq.stack) begin
					stk[sp] <= condReg;
					sp <= sp + 3'h1;
				end
				condReg[5] <= coreReq.level[1];
				condReg[3] <= coreReq.level[0];
				pc <= coreReq.vector;
			end else if (retGo) begin
				condReg <= stk[sp - 3'h1];
				sp <= sp - 3'h1;
			end else if (lvlSet[2]) begin
				condReg[5] <= lvlSet[1];
				condReg[3] <= lvlSet[0];
			end
		end
	end
endmodule // nprc_core_model

// ### bench/nprc_ctrl_bench.sv
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/10ps
module nprc_ctrl_bench import nprc_pkg::*;;
	logic        clk, rst_b, awvalid, wvalid, bready, arvalid, rready, nmiPin;
	logic        ackGo, retGo, trapGo, awready, wready, bvalid, arready, rvalid;
	logic        wakeWait, wakeHalt, haltGo;
	logic [7:0]  awaddr, araddr, periphFlag, periphClear;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  lvlSet;
	logic [39:0] extPins;
	nprc_core_t  coreIn;
	nprc_req_t   coreReq;
	int          errCount, comparisons;

	nprc_ctrl DUT (.clk(clk), .rst_b(rst_b), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.nmiPin(nmiPin), .extPins(extPins), .periphFlag(periphFlag),
		.periphClear(periphClear), .coreIn(coreIn), .coreReq(coreReq),
		.wakeWait(wakeWait), .wakeHalt(wakeHalt));
	nprc_core_model core (.clk(clk), .rst_b(rst_b), .coreReq(coreReq), .ackGo(ackGo),
		.retGo(retGo), .trapGo(trapGo), .haltGo(haltGo), .lvlSet(lvlSet), .coreIn(coreIn));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errCount++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		if (errCount == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [31:0] expReq(input logic [4:0] id, input logic [1:0] lv);
		logic [15:0] v;
		v = (id == 5'h0F) ? 16'hFFFE : (id == 5'h0E) ? 16'hFFFC : 16'hFFFA - {10'h000, id, 1'b0};
		return {7'h00, 1'b1, v, lv, id != 5'h0F, id};
	endfunction
	// each channel released at its own handshake, answer waited for
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic [1:0] r);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (arready) arvalid <= 1'b0;
		end while (!(w ? bvalid : rvalid));
		q = rdata;
		r = w ? bresp : rresp;
		bready <= 1'b0;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
		check({30'h0, r}, {30'h0, e});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 32'h0, q, r);
		check(q, d);
		check({30'h0, r}, {30'h0, e});
	endtask
	task automatic ack();
		ackGo <= 1'b1;
		cyc(1);
		ackGo <= 1'b0;
		cyc(3);
	endtask
	task automatic lvl(input logic [1:0] c);
		lvlSet <= {1'b1, c};
		cyc(1);
		lvlSet <= 3'h0;
		cyc(4);
	endtask
	task automatic clr();
		periphFlag <= 8'h00;
		periphClear <= 8'h01;
		cyc(1);
		periphClear <= 8'h00;
		cyc(4);
	endtask

	task automatic tReset();
		cyc(2);
		check({7'h00, coreReq}, expReq(ID_RESET, LVL_CODE_3));
		ack();
		check({31'h0, coreReq.req}, 32'h0);
	endtask
	task automatic tRegs();
		rdc(ADDR_PRIO0, 32'hFF, RESP_OKAY);
		rdc(ADDR_PRIO3, 32'hFF, RESP_OKAY);
		wrc(ADDR_PRIO0, 32'hCF, RESP_OKAY);
		wrc(ADDR_PRIO0, 32'h64, RESP_OKAY);
		rdc(ADDR_PRIO0, 32'h44, RESP_OKAY);
		wrc(8'h20, 32'h0, RESP_SLVERR);
		rdc(8'h22, 32'h0, RESP_SLVERR);
	endtask
	task automatic tPeriph();
		wrc(ADDR_PRIO1, 32'hDF, RESP_OKAY);
		wrc(ADDR_PERIEN, 32'h01, RESP_OKAY);
		lvl(LVL_CODE_1);
		periphFlag <= 8'h01;
		cyc(4);
		check({31'h0, coreReq.req}, 32'h0);
		rdc(ADDR_PEND, 32'h40, RESP_OKAY);
		lvl(LVL_CODE_0);
		check({7'h00, coreReq}, expReq(5'h06, LVL_CODE_1));
		check({31'h0, wakeWait}, 32'h1);
		clr();
		check({31'h0, coreReq.req}, 32'h0);
	endtask
	task automatic tOrder();
		wrc(ADDR_PRIO0, 32'hF7, RESP_OKAY);
		wrc(ADDR_PRIO1, 32'hFF, RESP_OKAY);
		wrc(ADDR_EXTSEL0, 32'h03, RESP_OKAY);
		periphFlag <= 8'h01;
		extPins <= 40'h02;
		cyc(4);
		check({7'h00, coreReq}, expReq(5'h06, LVL_CODE_3));
		ack();
		clr();
		lvl(LVL_CODE_0);
		check({7'h00, coreReq}, expReq(5'h01, LVL_CODE_1));
		ack();
		rdc(ADDR_PEND, 32'h0, RESP_OKAY);
	endtask
	task automatic tNonMask();
		lvl(LVL_CODE_3);
		nmiPin <= 1'b0;
		cyc(4);
		check({7'h00, coreReq}, expReq(5'h00, LVL_CODE_3));
		check({31'h0, wakeHalt}, 32'h1);
		ack();
		trapGo <= 1'b1;
		cyc(1);
		trapGo <= 1'b0;
		cyc(4);
		check({7'h00, coreReq}, expReq(ID_TRAP, LVL_CODE_3));
		ack();
		retGo <= 1'b1;
		cyc(1);
		retGo <= 1'b0;
	endtask
	// halted core: only a halt-capable vector may come first, the other follows
	task automatic tHalt();
		wrc(ADDR_PRIO2, 32'hF1, RESP_OKAY);
		wrc(ADDR_PERIEN, 32'h0C, RESP_OKAY);
		haltGo <= 1'b1;
		periphFlag <= 8'h0C;
		lvl(LVL_CODE_0);
		check({7'h00, coreReq}, expReq(5'h08, LVL_CODE_1));
		check({31'h0, wakeHalt}, 32'h1);
		haltGo <= 1'b0;
		ack();
		check({7'h00, coreReq}, expReq(5'h09, LVL_CODE_2));
		ack();
		check({31'h0, coreReq.req}, 32'h0);
		retGo <= 1'b1;
		cyc(1);
		retGo <= 1'b0;
		cyc(4);
		check({7'h00, coreReq}, expReq(5'h09, LVL_CODE_2));
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		cyc(5000);
		errCount++;
		summarize();
	end
	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready, ackGo, retGo, trapGo, haltGo} = 10'h000;
		{awaddr, araddr, periphFlag, periphClear, lvlSet} = 35'h0;
		{wdata, extPins} = 72'h0;
		nmiPin = 1'b1;
		errCount = 0;
		comparisons = 0;
		cyc(16);
		rst_b <= 1'b1;
		tReset();
		tRegs();
		tPeriph();
		tOrder();
		tNonMask();
		tHalt();
		summarize();
	end
endmodule // nprc_ctrl_bench

bind nprc_ctrl nprc_ctrl_check u_check (.clk(clk), .rst_b(rst_b), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .coreIn(coreIn),
	.coreReq(coreReq), .wakeWait(wakeWait));
